// file: logic/acc_control.sv
// Control logic for one analog comparator channel and its DAC.
// Assumes the Avalon-MM master, analog comparator, input mux and
// DAC sit outside; comparator output and PWM clock are async pins.
//
// Operation
// - The channel runs only while the comparator-on bit 15 is set.
// - With idle-stop bit 13 set the channel halts in Idle mode.
// - Any channel's idle-stop bit halts every channel in Idle mode.
// - Bits 12-11 pick no, 5 mV, 10 mV or 20 mV of hysteresis.
// - Bit 10 inserts the digital filter, else the filter is bypassed.
// - Bit 9 clocks filter and stretcher from PWM clock, else sysclk.
// - Bit 8 connects the DAC voltage to the DAC output pin.
// - With alternate input clear, bits 7-6 pick pin A, B, C or D.
// - With alternate input set, 00 and 01 pick gain amp one or two.
// - Bit 14 reads zero and ignores writes.
// - Status bit 3 is hardware owned, resets to 0, ignores writes.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_control #(
    parameter int ADDR_W      = 4,
    parameter int FILT_DEPTH  = `ACC_FILT_DEPTH,
    parameter int STRETCH     = `ACC_STRETCH
) (
    // Clock, reset, enable
    input  wire logic                  CLOCK,
    input  wire logic                  SRST,
    input  wire logic                  CE,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [3:0]            AVS_BYTEENABLE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    output logic      [31:0]           AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    // Device idle state and sibling channels
    input  wire logic                  IDLE_MODE,
    input  wire logic                  OTHER_IDLE_STOP,
    output logic                       IDLE_STOP_REQ,
    // Comparator side inputs
    input  wire logic                  COMP_RAW,
    input  wire logic                  PWM_CLK,
    // Comparator static controls
    output logic                       COMPARATOR_ON,
    output logic      [1:0]            HYSTERESIS_SELECT,
    output logic                       HYSTERESIS_POLARITY,
    output logic                       EXTERNAL_REFERENCE_SELECT,
    output logic                       OUTPUT_POLARITY,
    output logic                       RANGE_SELECT,
    output logic                       DAC_OUTPUT_ENABLE,
    output logic      [`ACC_MUX_W-1:0] INPUT_MUX_SEL,
    // Comparator result
    output logic                       COMPARATOR_STATE
);
    // Bus and register state
    acc_pkg::acc_bus_t bus_state;
    acc_pkg::acc_bus_t next_bus_state;
    logic [15:0]       ctrl;
    logic [15:0]       next_ctrl;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    logic [15:0]       lane_mask;
    logic              hit;

    // Synchronisers and levels
    logic [2:0]        raw_sync;
    logic [2:0]        pwm_sync;
    logic              raw_level;
    logic              pwm_level;
    logic              pwm_prev;
    logic              next_raw_level;
    logic              next_pwm_level;
    logic              pwm_rise;

    // Comparator path
    logic              run;
    logic              filt_tick;
    logic              filt_out;
    logic              comp_sel;
    logic              status;
    logic              next_status;
    logic [`ACC_MUX_W-1:0] mux_dec;
    acc_pkg::acc_hys_t hys;

    // Registered outputs
    logic              on_q;
    logic              dac_output_enable_q;
    logic [`ACC_MUX_W-1:0] mux_q;
    acc_pkg::acc_hys_t hys_q;
    logic [3:0]        stat_bits_q;
    logic              idle_req_q;

    assign hit       = (AVS_ADDRESS == `ACC_CTRL_OFS);
    assign lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}}
                       & `ACC_CTRL_WMASK;

    // Bus: take request in IDLE, answer with waitrequest low in DONE
    always_comb begin
        next_bus_state = bus_state;
        next_ctrl      = ctrl;
        next_rdata     = rdata;
        case (bus_state)
            acc_pkg::ACC_BUS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    next_bus_state = acc_pkg::ACC_BUS_DONE;
                    next_rdata     = 32'h0000_0000;
                    if (hit) begin
                        next_rdata[15:0] = ctrl;
                        next_rdata[`ACC_B_STAT] = status;
                    end
                end
            end
            acc_pkg::ACC_BUS_DONE: begin
                next_bus_state = acc_pkg::ACC_BUS_IDLE;
                if (AVS_WRITE && hit) begin
                    // Status and bit 14 are masked from writes
                    next_ctrl = (ctrl & ~lane_mask)
                                | (AVS_WRITEDATA[15:0] & lane_mask);
                end
            end
            default: begin
                next_bus_state = acc_pkg::ACC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            bus_state <= acc_pkg::ACC_BUS_IDLE;
            ctrl      <= `ACC_CTRL_RST;
            rdata     <= 32'h0000_0000;
        end else if (CE) begin
            bus_state <= next_bus_state;
            ctrl      <= next_ctrl;
            rdata     <= next_rdata;
        end
    end

    assign AVS_WAITREQUEST = !(bus_state == acc_pkg::ACC_BUS_DONE && CE);
    assign AVS_READDATA    = rdata;

    // Async pins: three flops, accept once stages two and three agree
    always_comb begin
        next_raw_level = raw_level;
        next_pwm_level = pwm_level;
        if (raw_sync[1] == raw_sync[2]) begin
            next_raw_level = raw_sync[2];
        end
        if (pwm_sync[1] == pwm_sync[2]) begin
            next_pwm_level = pwm_sync[2];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            raw_sync  <= 3'h0;
            pwm_sync  <= 3'h0;
            raw_level <= 1'b0;
            pwm_level <= 1'b0;
            pwm_prev  <= 1'b0;
        end else if (CE) begin
            raw_sync  <= {raw_sync[1:0], COMP_RAW};
            pwm_sync  <= {pwm_sync[1:0], PWM_CLK};
            raw_level <= next_raw_level;
            pwm_level <= next_pwm_level;
            pwm_prev  <= pwm_level;
        end
    end

    assign pwm_rise = pwm_level && !pwm_prev;

    // Channel run condition with shared idle stop
    assign run = ctrl[`ACC_B_ON]
                 && !(IDLE_MODE && (ctrl[`ACC_B_IDLE]
                                    || OTHER_IDLE_STOP));

    // Filter time base
    assign filt_tick = ctrl[`ACC_B_FCLK] ? pwm_rise : 1'b1;

    acc_filter #(
        .DEPTH   (FILT_DEPTH),
        .STRETCH (STRETCH)
    ) u_filter (
        .clk  (CLOCK),
        .srst (SRST),
        .ce   (CE),
        .tick (filt_tick),
        .din  (raw_level),
        .dout (filt_out)
    );

    assign comp_sel = ctrl[`ACC_B_FILT] ? filt_out : raw_level;

    // Status follows the polarised output only while running
    assign next_status = run && (comp_sel ^ ctrl[`ACC_B_POL]);

    // Input source decode, one line per mux input
    genvar g;
    generate
        for (g = 0; g < `ACC_MUX_W; g++) begin : g_mux
            if (g < `ACC_MUX_PINS) begin : g_pin
                assign mux_dec[g] = !ctrl[`ACC_B_ALT]
                    && (ctrl[`ACC_F_INPUT_SELECT] == 2'(g));
            end else begin : g_alt
                assign mux_dec[g] = ctrl[`ACC_B_ALT]
                    && (ctrl[`ACC_F_INPUT_SELECT] == 2'(g - `ACC_MUX_PINS));
            end
        end
    endgenerate

    assign hys = acc_pkg::acc_hys_t'(ctrl[`ACC_F_HYS]);

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            status      <= 1'b0;
            on_q        <= 1'b0;
            dac_output_enable_q     <= 1'b0;
            mux_q       <= '0;
            hys_q       <= acc_pkg::ACC_HYS_NONE;
            stat_bits_q <= 4'h0;
            idle_req_q  <= 1'b0;
        end else if (CE) begin
            status      <= next_status;
            on_q        <= run;
            dac_output_enable_q     <= ctrl[`ACC_B_DAC_OUTPUT_ENABLE];
            mux_q       <= mux_dec;
            hys_q       <= hys;
            stat_bits_q <= {ctrl[`ACC_B_EXTERNAL_REFERENCE_SELECT], ctrl[`ACC_B_HYSTERESIS_POLARITY],
                            ctrl[`ACC_B_POL], ctrl[`ACC_B_RANGE]};
            idle_req_q  <= ctrl[`ACC_B_IDLE];
        end
    end

    assign COMPARATOR_ON             = on_q;
    assign HYSTERESIS_SELECT         = hys_q;
    assign DAC_OUTPUT_ENABLE         = dac_output_enable_q;
    assign INPUT_MUX_SEL             = mux_q;
    assign EXTERNAL_REFERENCE_SELECT = stat_bits_q[3];
    assign HYSTERESIS_POLARITY       = stat_bits_q[2];
    assign OUTPUT_POLARITY           = stat_bits_q[1];
    assign RANGE_SELECT              = stat_bits_q[0];
    assign IDLE_STOP_REQ             = idle_req_q;
    assign COMPARATOR_STATE          = status;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    a_off_disables: assert property (
        CE && !ctrl[`ACC_B_ON] |=> !COMPARATOR_ON && !COMPARATOR_STATE)
        else $error("channel runs while switched off");

    a_idle_own_stop: assert property (
        CE && IDLE_MODE && ctrl[`ACC_B_IDLE] |=> !COMPARATOR_ON)
        else $error("own idle stop ignored");

    a_idle_keep_run: assert property (
        CE && ctrl[`ACC_B_ON] && !ctrl[`ACC_B_IDLE] && !OTHER_IDLE_STOP
        |=> COMPARATOR_ON)
        else $error("channel stopped without idle stop");

    a_idle_other_stop: assert property (
        CE && IDLE_MODE && OTHER_IDLE_STOP |=> !COMPARATOR_ON)
        else $error("sibling idle stop ignored");

    a_hyst_code_map: assert property (
        CE |=> HYSTERESIS_SELECT == $past(ctrl[`ACC_F_HYS]))
        else $error("hysteresis code mismatch");

    a_filter_bypass: assert property (
        CE && run && !ctrl[`ACC_B_FILT]
        |=> COMPARATOR_STATE == $past(raw_level ^ ctrl[`ACC_B_POL]))
        else $error("bypass path wrong");

    a_filter_sysclk: assert property (
        CE && !ctrl[`ACC_B_FCLK] |-> filt_tick)
        else $error("filter lost system clock tick");

    a_dac_pin_link: assert property (
        CE |=> DAC_OUTPUT_ENABLE == $past(ctrl[`ACC_B_DAC_OUTPUT_ENABLE]))
        else $error("dac output enable mismatch");

    a_pin_route: assert property (
        CE && !SRST && !ctrl[`ACC_B_ALT]
        |=> INPUT_MUX_SEL == (6'h01 << $past(ctrl[`ACC_F_INPUT_SELECT])))
        else $error("pin input routing wrong");

    a_gain_route: assert property (
        CE && !SRST && ctrl[`ACC_B_ALT]
        |=> INPUT_MUX_SEL == (($past(ctrl[`ACC_F_INPUT_SELECT]) > 2'h1) ? 6'h00
            : (6'h10 << $past(ctrl[`ACC_F_INPUT_SELECT]))))
        else $error("alternate input routing wrong");

    a_unimp_zero: assert property (
        !AVS_WAITREQUEST && AVS_READ |-> !AVS_READDATA[`ACC_B_UNIMP])
        else $error("unimplemented bit reads one");

    a_status_hw_only: assert property (
        CE && !AVS_WAITREQUEST && AVS_WRITE |=> !ctrl[`ACC_B_STAT])
        else $error("software reached status bit");

    a_status_follow: assert property (
        CE && run |=> COMPARATOR_STATE
            == $past(comp_sel ^ ctrl[`ACC_B_POL]))
        else $error("status does not follow comparator");

    a_static_bits: assert property (
        CE |=> OUTPUT_POLARITY == $past(ctrl[`ACC_B_POL])
            && RANGE_SELECT == $past(ctrl[`ACC_B_RANGE])
            && HYSTERESIS_POLARITY == $past(ctrl[`ACC_B_HYSTERESIS_POLARITY])
            && EXTERNAL_REFERENCE_SELECT == $past(ctrl[`ACC_B_EXTERNAL_REFERENCE_SELECT]))
        else $error("static control bit mismatch");

endmodule : acc_control

// file: logic/acc_params.svh
// Constants for the analog comparator channel control block.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register map, byte address on the Avalon-MM slave
`define ACC_CTRL_OFS    4'h0
`define ACC_CTRL_RST    16'h0000
`define ACC_CTRL_WMASK  16'hBFF7

// Control register fields
`define ACC_B_ON        15
`define ACC_B_UNIMP     14
`define ACC_B_IDLE      13
`define ACC_F_HYS       12:11
`define ACC_B_FILT      10
`define ACC_B_FCLK      9
`define ACC_B_DAC_OUTPUT_ENABLE     8
`define ACC_F_INPUT_SELECT     7:6
`define ACC_B_EXTERNAL_REFERENCE_SELECT    5
`define ACC_B_HYSTERESIS_POLARITY    4
`define ACC_B_STAT      3
`define ACC_B_ALT       2
`define ACC_B_POL       1
`define ACC_B_RANGE     0

// Input multiplexer one-hot positions
`define ACC_MUX_PINS    4
`define ACC_MUX_W       6

// Filter timing in filter ticks
`define ACC_FILT_DEPTH  3
`define ACC_STRETCH     2

`endif

// file: logic/acc_pkg.sv
// Types for the analog comparator channel control block.
// Assumes acc_params.svh holds the numeric constants.
package acc_pkg;

    typedef enum logic [0:0] {
        ACC_BUS_IDLE = 1'h0,
        ACC_BUS_DONE = 1'h1
    } acc_bus_t;

    typedef enum logic [1:0] {
        ACC_HYS_NONE = 2'h0,
        ACC_HYS_5MV  = 2'h1,
        ACC_HYS_10MV = 2'h2,
        ACC_HYS_20MV = 2'h3
    } acc_hys_t;

endpackage : acc_pkg

// file: logic/acc_filter.sv
// Digital output filter with pulse stretcher for the comparator.
// Assumes a tick enable that marks each filter clock period.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_filter #(
    parameter int DEPTH   = `ACC_FILT_DEPTH,
    parameter int STRETCH = `ACC_STRETCH
) (
    // Clock, reset, enables
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic tick,
    // Data
    input  wire logic din,
    output logic      dout
);
    localparam int CW = $clog2(DEPTH + STRETCH + 1);

    logic [CW-1:0] agree;
    logic [CW-1:0] next_agree;
    logic [CW-1:0] hold;
    logic [CW-1:0] next_hold;
    logic          level;
    logic          next_level;

    // Change only after DEPTH agreeing ticks; highs last STRETCH ticks
    always_comb begin
        next_agree = agree;
        next_hold  = hold;
        next_level = level;
        if (tick) begin
            if (hold != '0) begin
                next_hold = hold - 1'b1;
            end
            if (din == level) begin
                next_agree = '0;
            end else if (agree != CW'(DEPTH - 1)) begin
                next_agree = agree + 1'b1;
            end else if (!(level && hold != '0)) begin
                next_level = din;
                next_agree = '0;
                if (din) begin
                    next_hold = CW'(STRETCH);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            agree <= '0;
            hold  <= '0;
            level <= 1'b0;
        end else if (ce) begin
            agree <= next_agree;
            hold  <= next_hold;
            level <= next_level;
        end
    end

    assign dout = level;

endmodule : acc_filter

// file: tb/acc_comp_model.sv
// Behavioural analog comparator and PWM clock source for the bench.
// Assumes the bench sets the comparator level and starts the PWM clock.
`timescale 1ns/1ps
module acc_comp_model (
    // Clock
    input  wire logic CLOCK,
    // Bench controls
    input  wire logic level,
    input  wire logic pwm_run,
    // Comparator side pins
    output logic      COMP_RAW,
    output logic      PWM_CLK
);
    logic [1:0] div = 2'h0;

    // Analog decision follows the selected input level
    assign COMP_RAW = level;

    // PWM clock stands still at 0 unless running
    always @(posedge CLOCK) begin
        div <= pwm_run ? div + 2'h1 : 2'h0;
        PWM_CLK <= pwm_run && (div == 2'h3) ? ~PWM_CLK : PWM_CLK & pwm_run;
    end
endmodule : acc_comp_model

// file: tb/analog_comparator_control_tb.sv
// Self-checking bench for the comparator channel control block.
// Assumes acc_control as device and acc_comp_model as comparator.
`timescale 1ns/1ps
module analog_comparator_control_tb;
    logic        CLOCK = 1'b0;
    logic        SRST = 1'b1;
    logic        CE = 1'b1;
    logic [3:0]  AVS_ADDRESS = 4'h0;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [3:0]  AVS_BYTEENABLE = 4'h3;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        IDLE_MODE = 1'b0;
    logic        OTHER_IDLE_STOP = 1'b0;
    logic        IDLE_STOP_REQ, COMPARATOR_ON, HYSTERESIS_POLARITY;
    logic        EXTERNAL_REFERENCE_SELECT, OUTPUT_POLARITY, RANGE_SELECT;
    logic        DAC_OUTPUT_ENABLE, COMPARATOR_STATE, COMP_RAW, PWM_CLK;
    logic [1:0]  HYSTERESIS_SELECT;
    logic [5:0]  INPUT_MUX_SEL;
    logic        level = 1'b0;
    logic        pwm_run = 1'b0;
    logic [31:0] rd;
    logic [15:0] w;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #20 CLOCK = ~CLOCK;

    acc_control dut (.CLOCK(CLOCK), .SRST(SRST), .CE(CE),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .IDLE_MODE(IDLE_MODE),
        .OTHER_IDLE_STOP(OTHER_IDLE_STOP), .IDLE_STOP_REQ(IDLE_STOP_REQ),
        .COMP_RAW(COMP_RAW), .PWM_CLK(PWM_CLK),
        .COMPARATOR_ON(COMPARATOR_ON),
        .HYSTERESIS_SELECT(HYSTERESIS_SELECT),
        .HYSTERESIS_POLARITY(HYSTERESIS_POLARITY),
        .EXTERNAL_REFERENCE_SELECT(EXTERNAL_REFERENCE_SELECT),
        .OUTPUT_POLARITY(OUTPUT_POLARITY), .RANGE_SELECT(RANGE_SELECT),
        .DAC_OUTPUT_ENABLE(DAC_OUTPUT_ENABLE),
        .INPUT_MUX_SEL(INPUT_MUX_SEL), .COMPARATOR_STATE(COMPARATOR_STATE));

    acc_comp_model model (.CLOCK(CLOCK), .level(level), .pwm_run(pwm_run),
        .COMP_RAW(COMP_RAW), .PWM_CLK(PWM_CLK));

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One Avalon-MM access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {16'h0000, d};
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        do begin
            @(posedge CLOCK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        chk(32'(n), 32'h2, "answer latency");
    endtask : bus

    task automatic wr_settle(input logic [15:0] d);
        bus(1'b1, 4'h0, d);
        repeat (3) @(posedge CLOCK);
    endtask : wr_settle

    // Status must reach v within lim cycles
    task automatic wait_stat(input logic v, input int lim, input string m);
        int n;
        n = 0;
        while (COMPARATOR_STATE !== v && n < lim) begin
            @(posedge CLOCK);
            n++;
        end
        chk({31'h0, COMPARATOR_STATE}, {31'h0, v}, m);
    endtask : wait_stat

    // Status must stay 0 for n cycles
    task automatic hold0(input int n, input string m);
        repeat (n) begin
            @(posedge CLOCK);
            if (COMPARATOR_STATE !== 1'b0) begin
                miscompares++;
                $display("mismatch %0t %s", $time, m);
            end
        end
        n_tests++;
    endtask : hold0

    initial begin
        repeat (16) @(posedge CLOCK);
        SRST <= 1'b0;
        @(posedge CLOCK);
        bus(1'b0, 4'h0, 16'h0000);
        chk(rd, 32'h0, "reset value");
        chk({26'h0, INPUT_MUX_SEL}, 32'h1, "reset mux");
        $display("test reset done");
        // Every field but bit 1 written, bits 14 and 3 stay 0
        wr_settle(16'hFFFD);
        bus(1'b0, 4'h0, 16'h0000);
        chk(rd, 32'hBFF5, "readback");
        chk({28'h0, HYSTERESIS_SELECT, DAC_OUTPUT_ENABLE, IDLE_STOP_REQ},
            32'hF, "statics");
        chk({28'h0, EXTERNAL_REFERENCE_SELECT, HYSTERESIS_POLARITY,
             OUTPUT_POLARITY, RANGE_SELECT}, 32'hD, "plain bits");
        chk({26'h0, INPUT_MUX_SEL}, 32'h0, "reserved alt");
        // Clearing the register turns off the DAC pin and the channel
        wr_settle(16'h0000);
        chk({31'h0, DAC_OUTPUT_ENABLE}, 32'h0, "dac off");
        chk({31'h0, COMPARATOR_ON}, 32'h0, "off");
        $display("test fields done");
        // Unmapped address reads 0 and ignores writes
        bus(1'b1, 4'h4, 16'h8000);
        bus(1'b0, 4'h4, 16'h0000);
        chk(rd, 32'h0, "unmapped read");
        bus(1'b0, 4'h0, 16'h0000);
        chk(rd, 32'h0, "unmapped write");
        // Only byte lane 1 written
        AVS_BYTEENABLE <= 4'h2;
        bus(1'b1, 4'h0, 16'hFFFF);
        AVS_BYTEENABLE <= 4'h3;
        bus(1'b0, 4'h0, 16'h0000);
        chk(rd, 32'hBF00, "lane mask");
        // Input select and hysteresis codes
        for (int a = 0; a < 2; a++) begin
            for (int s = 0; s < 4; s++) begin
                w = 16'h8000 | 16'(s << 11) | 16'(s << 6) | 16'(a << 2);
                wr_settle(w);
                chk({26'h0, INPUT_MUX_SEL}, a == 0 ? 32'h1 << s :
                    (s < 2 ? 32'h10 << s : 32'h0), "mux");
                chk({30'h0, HYSTERESIS_SELECT}, 32'(s), "hys");
            end
        end
        $display("test select done");
        // Idle mode stop, own bit and sibling bit
        IDLE_MODE <= 1'b1;
        level <= 1'b1;
        wr_settle(16'hA000);
        chk({31'h0, COMPARATOR_ON}, 32'h0, "own idle stop");
        hold0(10, "status while stopped");
        wr_settle(16'h8000);
        chk({31'h0, COMPARATOR_ON}, 32'h1, "idle run");
        OTHER_IDLE_STOP <= 1'b1;
        repeat (3) @(posedge CLOCK);
        chk({31'h0, COMPARATOR_ON}, 32'h0, "sibling stop");
        IDLE_MODE <= 1'b0;
        OTHER_IDLE_STOP <= 1'b0;
        $display("test idle done");
        // Bypass: status follows level, polarity inverts it
        wait_stat(1'b1, 8, "bypass follow");
        bus(1'b0, 4'h0, 16'h0000);
        chk(rd, 32'h8008, "status read");
        wr_settle(16'h8002);
        wait_stat(1'b0, 8, "polarity");
        // Clock enable low freezes the status path
        CE <= 1'b0;
        level <= 1'b0;
        hold0(10, "frozen by enable");
        CE <= 1'b1;
        wait_stat(1'b1, 10, "enable resumed");
        wr_settle(16'h0000);
        hold0(10, "status off");
        // Filter on sysclk rejects a short pulse
        level <= 1'b0;
        wr_settle(16'h8400);
        level <= 1'b1;
        repeat (2) @(posedge CLOCK);
        level <= 1'b0;
        hold0(20, "glitch passed");
        level <= 1'b1;
        wait_stat(1'b1, 30, "filter pass");
        $display("test filter done");
        // Filter on PWM clock needs PWM ticks
        level <= 1'b0;
        wait_stat(1'b0, 40, "pwm low");
        wr_settle(16'h8600);
        level <= 1'b1;
        hold0(40, "no pwm ticks");
        pwm_run <= 1'b1;
        wait_stat(1'b1, 120, "pwm ticks");
        pwm_run <= 1'b0;
        $display("test pwm done");
        summarize();
    end
endmodule : analog_comparator_control_tb
